/* mbs_params.svh */
// constants of the memory bus strobe and select block
`ifndef MBS_PARAMS_SVH
`define MBS_PARAMS_SVH

// ------------------------------------------------------------
// widths and field positions
// ------------------------------------------------------------
`define MBS_ADDR_W        24
`define MBS_DATA_W        16
`define MBS_TOP_BIT       23
`define MBS_IRQ_N         4
`define MBS_SVC_NMI       3'h4

// ------------------------------------------------------------
// reset values
// ------------------------------------------------------------
`define MBS_STROBE_IDLE   1'h1
`define MBS_ADDR_RST      24'h000000
`define MBS_DATA_RST      16'h0000

// ------------------------------------------------------------
// timing: reset hold in bus clock periods, i/o divider codes
// ------------------------------------------------------------
`define MBS_RESET_MIN_PERIODS 5
`define MBS_IODIV_W       3
`define MBS_IODIV_BASE    3'h2

`endif

/* mbs_pkg.sv */
// types shared by the memory bus strobe and select block
package mbs_pkg;

  typedef enum logic [2:0] {
    MBS_IDLE = 3'b000,
    MBS_T1   = 3'b001,
    MBS_T2   = 3'b010,
    MBS_T3   = 3'b011,
    MBS_TW   = 3'b100,
    MBS_T4   = 3'b101
  } mbs_state_t;

  typedef enum logic [1:0] {
    MBS_MEM_RD  = 2'b00,
    MBS_MEM_WR  = 2'b01,
    MBS_REFRESH = 2'b10,
    MBS_IO      = 2'b11
  } mbs_kind_t;

  // i/o clock divide code: factor is 2 * (code + 1)
  typedef enum logic [1:0] {
    MBS_DIV2 = 2'b00,
    MBS_DIV4 = 2'b01,
    MBS_DIV6 = 2'b10,
    MBS_DIV8 = 2'b11
  } mbs_iodiv_t;

endpackage : mbs_pkg

/* mbs_bus_ctrl.sv */
// memory bus controller: strobes, timing references, chip selects, wait and nmi
//
// Behaviour
// RQ1: write strobe low from close of T2 through close of T4.
// RQ2: byte enables accompanying write strobe select which bytes are stored.
// RQ3: nmi taken on falling edge, served ahead of the four maskable requests.
// RQ4: reset source holds reset low at least five bus clock periods.
// RQ5: after reset, top bit zero asserts rom select and pulls byte sense low.
// RQ6: rom select address range reprogrammable through chip select configuration.
// RQ7: a setting stops rom byte forcing so paired byte roms run as words.
// RQ8: after reset, top bit one asserts low ram select; high select is port pin.
// RQ9: without ram byte forcing, ram selects gated by low and high byte enables.
// RQ10: ram selects change with the address, no extra delay.
// RQ11: reference A falls at close of T2, rises at close of T4.
// RQ12: column reference falls at close of T3, rises at close of T4.
// RQ13: row reference falls at close of T1, rises at close of T4.
// RQ14: wait sampled on bus clock, or i/o clock for i/o, inserts wait states.
// RQ15: read strobe low from close of T1 through close of T4.
// RQ16: byte sense low on word operation runs extra low-lane transaction for other byte.
// RQ17: i/o clock is bus clock divided by two, four, six or eight, or disabled.
// RQ18: wait states stretch before T4, strobes held until wait seen released.
`timescale 1ns/10ps
`default_nettype none
`include "mbs_params.svh"

module mbs_bus_ctrl (
  input  wire logic                   clk,
  input  wire logic                   rst_n,
  // core request side
  input  wire logic                   req_valid,
  input  wire mbs_pkg::mbs_kind_t     req_kind,
  input  wire logic                   req_word,
  input  wire logic [`MBS_ADDR_W-1:0] req_addr,
  input  wire logic [`MBS_DATA_W-1:0] req_wdata,
  output logic                        req_ready,
  output logic                        done_pulse,
  output logic [`MBS_DATA_W-1:0]      rd_data,
  // chip select configuration
  input  wire logic                   cs_programmed,
  input  wire logic [`MBS_ADDR_W-1:0] rom_base,
  input  wire logic [`MBS_ADDR_W-1:0] rom_mask,
  input  wire logic                   rom_word_mode,
  input  wire logic                   ram_word_mode,
  input  wire logic                   ram_high_port_value,
  input  wire logic                   io_clock_enable,
  input  wire mbs_pkg::mbs_iodiv_t    io_div,
  // memory pins
  output logic [`MBS_ADDR_W-1:0]      addr_out,
  output logic [`MBS_DATA_W-1:0]      data_out,
  output logic                        data_oe,
  input  wire logic [`MBS_DATA_W-1:0] data_in,
  output logic                        memory_read_strobe_n,
  output logic                        memory_write_strobe_n,
  output logic                        high_byte_enable_n,
  output logic                        low_byte_enable_n,
  output logic                        timing_reference_a_n,
  output logic                        column_strobe_reference_n,
  output logic                        row_strobe_reference_n,
  output logic                        rom_select_n,
  output logic                        ram_select_low_n,
  output logic                        ram_select_high_n,
  input  wire logic                   byte_width_sense_in,
  output logic                        byte_width_sense_out,
  output logic                        byte_width_sense_oe,
  input  wire logic                   wait_n,
  output logic                        io_clock,
  // interrupt inputs and service code
  input  wire logic                   nmi_n,
  input  wire logic [`MBS_IRQ_N-1:0]  maskable_irq_inputs_n,
  input  wire logic                   int_ack,
  output logic                        int_valid,
  output logic [2:0]                  int_source
);
  import mbs_pkg::*;

  // ------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------
  logic                   wait_s1_q, wait_s2_q;
  logic                   nmi_s1_q, nmi_s2_q, nmi_prev_q;
  logic [`MBS_IRQ_N-1:0]  irq_s1_q, irq_s2_q;
  logic                   sense_s1_q, sense_s2_q;
  logic [`MBS_DATA_W-1:0] din_s1_q, din_s2_q;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wait_s1_q  <= 1'h1;
      wait_s2_q  <= 1'h1;
      nmi_s1_q   <= 1'h1;
      nmi_s2_q   <= 1'h1;
      nmi_prev_q <= 1'h1;
      irq_s1_q   <= '1;
      irq_s2_q   <= '1;
      sense_s1_q <= 1'h1;
      sense_s2_q <= 1'h1;
      din_s1_q   <= `MBS_DATA_RST;
      din_s2_q   <= `MBS_DATA_RST;
    end else begin
      wait_s1_q  <= wait_n;
      wait_s2_q  <= wait_s1_q;
      nmi_s1_q   <= nmi_n;
      nmi_s2_q   <= nmi_s1_q;
      nmi_prev_q <= nmi_s2_q;
      irq_s1_q   <= maskable_irq_inputs_n;
      irq_s2_q   <= irq_s1_q;
      sense_s1_q <= byte_width_sense_in;
      sense_s2_q <= sense_s1_q;
      din_s1_q   <= data_in;
      din_s2_q   <= din_s1_q;
    end
  end

  // ------------------------------------------------------------
  // i/o clock divider
  // ------------------------------------------------------------
  logic [`MBS_IODIV_W-1:0] io_cnt_q;
  logic [`MBS_IODIV_W-1:0] io_last;
  logic                    io_tick;

  // factor 2*(code+1); last count is factor-1
  assign io_last = `MBS_IODIV_W'({io_div, 1'b1});
  assign io_tick = !io_clock_enable || (io_cnt_q == io_last);

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      io_cnt_q <= '0;
      io_clock <= 1'h0;
    end else if (!io_clock_enable) begin
      io_cnt_q <= '0; // RQ17
      io_clock <= 1'h0;
    end else begin
      io_cnt_q <= (io_cnt_q == io_last) ? '0 : io_cnt_q + 1'b1; // RQ17
      io_clock <= (io_cnt_q == io_last) || (io_cnt_q < io_div); // RQ17
    end
  end

  // ------------------------------------------------------------
  // transaction sequencer
  // ------------------------------------------------------------
  mbs_state_t             state_q, state_d;
  mbs_kind_t              kind_q;
  logic                   word_q, second_q;
  logic [`MBS_ADDR_W-1:0] cur_addr_q;
  logic [`MBS_DATA_W-1:0] wdata_q;
  logic                   step, start, split;

  // i/o cycles advance on the divided clock, memory on every edge
  assign step  = (kind_q == MBS_IO) ? io_tick : 1'b1;
  assign start = (state_q == MBS_IDLE) && req_valid;
  // the byte device pulled sense low: a word needs a second low-lane cycle
  assign split = word_q && !second_q && !sense_s2_q && (kind_q != MBS_REFRESH); // RQ16

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      MBS_IDLE: if (req_valid) state_d = MBS_T1;
      MBS_T1:   if (step) state_d = MBS_T2;
      MBS_T2:   if (step) state_d = MBS_T3;
      // wait sampled each step; strobes stay while wait stays low
      MBS_T3, MBS_TW: if (step) state_d = wait_s2_q ? MBS_T4 : MBS_TW; // RQ14 RQ18
      MBS_T4:   if (step) state_d = split ? MBS_T1 : MBS_IDLE; // RQ16
      default:  state_d = MBS_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_q    <= MBS_IDLE;
      kind_q     <= MBS_MEM_RD;
      word_q     <= 1'h0;
      second_q   <= 1'h0;
      cur_addr_q <= `MBS_ADDR_RST;
      wdata_q    <= `MBS_DATA_RST;
    end else begin
      state_q <= state_d;
      if (start) begin
        kind_q     <= req_kind;
        word_q     <= req_word;
        second_q   <= 1'h0;
        cur_addr_q <= req_addr;
        wdata_q    <= req_wdata;
      end else if (state_q == MBS_T4 && step && split) begin
        second_q   <= 1'h1; // RQ16
        cur_addr_q <= cur_addr_q + 1'b1;
        wdata_q    <= {8'h00, wdata_q[15:8]};
      end
    end
  end

  // ------------------------------------------------------------
  // address decode and chip selects
  // ------------------------------------------------------------
  logic [`MBS_ADDR_W-1:0] nxt_addr;
  logic                   nxt_mem, nxt_rom, nxt_ram, nxt_ble, nxt_bhe, nxt_force;
  logic                   cyc_force_q;

  always_comb begin
    nxt_addr = cur_addr_q;
    nxt_mem  = (kind_q == MBS_MEM_RD) || (kind_q == MBS_MEM_WR);
    if (start) begin
      nxt_addr = req_addr;
      nxt_mem  = (req_kind == MBS_MEM_RD) || (req_kind == MBS_MEM_WR);
    end else if (state_q == MBS_T4 && step && split) begin
      nxt_addr = cur_addr_q + 1'b1;
    end
    // default map by top bit until the range is programmed
    nxt_rom = nxt_mem && (cs_programmed ? ((nxt_addr & rom_mask) == rom_base)
                                        : !nxt_addr[`MBS_TOP_BIT]); // RQ5 RQ6
    nxt_ram = nxt_mem && !nxt_rom && nxt_addr[`MBS_TOP_BIT]; // RQ8
    // second half of a split word always rides the low lane
    if (start) begin
      nxt_ble = !req_word ? !req_addr[0] : 1'b1;
      nxt_bhe = !req_word ? req_addr[0] : 1'b1;
    end else if (second_q || (state_q == MBS_T4 && step && split)) begin
      nxt_ble = 1'b1; // RQ16
      nxt_bhe = 1'b0;
    end else begin
      nxt_ble = !word_q ? !cur_addr_q[0] : 1'b1;
      nxt_bhe = !word_q ? cur_addr_q[0] : 1'b1;
    end
    nxt_force = (nxt_rom && !rom_word_mode) || (nxt_ram && !ram_word_mode); // RQ7
  end

  // selects are registered with the address so they move together
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      addr_out           <= `MBS_ADDR_RST;
      rom_select_n       <= `MBS_STROBE_IDLE;
      ram_select_low_n   <= `MBS_STROBE_IDLE;
      ram_select_high_n  <= `MBS_STROBE_IDLE;
      low_byte_enable_n  <= `MBS_STROBE_IDLE;
      high_byte_enable_n <= `MBS_STROBE_IDLE;
      cyc_force_q        <= 1'h0;
    end else if (state_d == MBS_IDLE) begin
      rom_select_n       <= `MBS_STROBE_IDLE;
      ram_select_low_n   <= `MBS_STROBE_IDLE;
      ram_select_high_n  <= ram_word_mode ? `MBS_STROBE_IDLE : !ram_high_port_value; // RQ8
      low_byte_enable_n  <= `MBS_STROBE_IDLE;
      high_byte_enable_n <= `MBS_STROBE_IDLE;
      cyc_force_q        <= 1'h0;
    end else begin
      addr_out           <= nxt_addr; // RQ10
      rom_select_n       <= !nxt_rom; // RQ5
      low_byte_enable_n  <= !nxt_ble; // RQ2
      high_byte_enable_n <= !nxt_bhe; // RQ2
      cyc_force_q        <= nxt_force;
      if (ram_word_mode) begin
        ram_select_low_n  <= !(nxt_ram && nxt_ble); // RQ9 RQ10
        ram_select_high_n <= !(nxt_ram && nxt_bhe); // RQ9 RQ10
      end else begin
        ram_select_low_n  <= !nxt_ram; // RQ8
        ram_select_high_n <= !ram_high_port_value; // RQ8
      end
    end
  end

  // open-drain byte sense: drive low only while a forcing range is hit
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      byte_width_sense_out <= 1'h0;
      byte_width_sense_oe  <= 1'h0;
    end else begin
      byte_width_sense_out <= 1'h0;
      byte_width_sense_oe  <= (state_d != MBS_IDLE) && nxt_force; // RQ5 RQ7 RQ8
    end
  end

  // ------------------------------------------------------------
  // strobes and timing references
  // ------------------------------------------------------------
  logic in_t2_t4, in_t3_t4, in_tw_t4, is_mem, is_ref;

  assign in_t2_t4 = (state_d == MBS_T2) || (state_d == MBS_T3) || (state_d == MBS_TW) || (state_d == MBS_T4);
  assign in_t3_t4 = (state_d == MBS_T3) || (state_d == MBS_TW) || (state_d == MBS_T4);
  // waits only follow T3, so the column reference stays low through them
  assign in_tw_t4 = (state_d == MBS_TW) || (state_d == MBS_T4);
  assign is_mem   = (kind_q == MBS_MEM_RD) || (kind_q == MBS_MEM_WR) || (kind_q == MBS_REFRESH);
  assign is_ref   = is_mem && !start;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      memory_read_strobe_n      <= `MBS_STROBE_IDLE;
      memory_write_strobe_n     <= `MBS_STROBE_IDLE;
      row_strobe_reference_n    <= `MBS_STROBE_IDLE;
      timing_reference_a_n      <= `MBS_STROBE_IDLE;
      column_strobe_reference_n <= `MBS_STROBE_IDLE;
    end else begin
      memory_read_strobe_n      <= !(is_ref && kind_q == MBS_MEM_RD && in_t2_t4); // RQ15
      memory_write_strobe_n     <= !(is_ref && kind_q == MBS_MEM_WR && in_t3_t4); // RQ1
      row_strobe_reference_n    <= !(is_ref && in_t2_t4); // RQ13
      timing_reference_a_n      <= !(is_ref && in_t3_t4); // RQ11
      column_strobe_reference_n <= !(is_ref && in_tw_t4); // RQ12
    end
  end

  // ------------------------------------------------------------
  // data path and core handshake
  // ------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      data_out   <= `MBS_DATA_RST;
      data_oe    <= 1'h0;
      rd_data    <= `MBS_DATA_RST;
      done_pulse <= 1'h0;
      req_ready  <= 1'h0;
    end else begin
      data_out   <= wdata_q;
      data_oe    <= (kind_q == MBS_MEM_WR) && in_t2_t4 && !start;
      done_pulse <= (state_q == MBS_T4) && step && !split;
      req_ready  <= (state_d == MBS_IDLE) && !start;
      // refresh leaves the last read data standing
      if (state_q == MBS_T4 && step && (kind_q == MBS_MEM_RD || kind_q == MBS_IO)) begin
        if (second_q)
          rd_data[15:8] <= din_s2_q[7:0]; // RQ16
        else
          rd_data <= din_s2_q;
      end
    end
  end

  // ------------------------------------------------------------
  // interrupt intake: nmi latched on falling edge, ahead of irqs
  // ------------------------------------------------------------
  logic nmi_pend_q;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      nmi_pend_q <= 1'h0;
    end else if (nmi_prev_q && !nmi_s2_q) begin
      nmi_pend_q <= 1'h1; // RQ3
    end else if (int_ack && int_source == `MBS_SVC_NMI) begin
      nmi_pend_q <= 1'h0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      int_valid  <= 1'h0;
      int_source <= 3'h0;
    end else begin
      int_valid <= nmi_pend_q || (irq_s2_q != '1);
      if (nmi_pend_q)
        int_source <= `MBS_SVC_NMI; // RQ3
      else if (!irq_s2_q[0])
        int_source <= 3'h0;
      else if (!irq_s2_q[1])
        int_source <= 3'h1;
      else if (!irq_s2_q[2])
        int_source <= 3'h2;
      else
        int_source <= 3'h3;
    end
  end

endmodule : mbs_bus_ctrl
`default_nettype wire

/* mbs_bus_ctrl_asserts.sv */
// concurrent checks on the pins of the memory bus strobe and select block
`timescale 1ns/10ps
`default_nettype none
`include "mbs_params.svh"
module mbs_bus_ctrl_asserts (
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic        cs_programmed,
  input wire logic        rom_word_mode,
  input wire logic        ram_word_mode,
  input wire logic [23:0] addr_out,
  input wire logic        memory_read_strobe_n,
  input wire logic        memory_write_strobe_n,
  input wire logic        high_byte_enable_n,
  input wire logic        low_byte_enable_n,
  input wire logic        timing_reference_a_n,
  input wire logic        column_strobe_reference_n,
  input wire logic        row_strobe_reference_n,
  input wire logic        rom_select_n,
  input wire logic        ram_select_low_n,
  input wire logic        ram_select_high_n,
  input wire logic        byte_width_sense_oe,
  input wire logic        data_oe,
  input wire logic        byte_width_sense_out,
  input wire logic        wait_n,
  input wire logic        nmi_n,
  input wire logic        int_valid,
  input wire logic [2:0]  int_source
);
  // ----------------------------------------
  // strobe order, selects, wait, nmi
  // ----------------------------------------
  wire logic xfer = !memory_read_strobe_n || !memory_write_strobe_n;
  wire logic ram_map = addr_out[23] && !cs_programmed;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  AST_REF_ORDER: assert property ($fell(row_strobe_reference_n) |=>
    $fell(timing_reference_a_n) ##1 $fell(column_strobe_reference_n)) else $error("reference strobes out of order");
  AST_REF_RISE: assert property ($rose(row_strobe_reference_n) |->
    $rose(timing_reference_a_n) && $rose(column_strobe_reference_n)) else $error("references rise apart");
  AST_WR_START: assert property ($fell(memory_write_strobe_n) |-> $fell(timing_reference_a_n))
    else $error("write strobe start wrong");
  AST_WR_END: assert property ($rose(memory_write_strobe_n) |-> $rose(row_strobe_reference_n))
    else $error("write strobe end wrong");
  AST_RD_START: assert property ($fell(memory_read_strobe_n) |-> $fell(row_strobe_reference_n))
    else $error("read strobe start wrong");
  AST_WR_DRIVE: assert property (!memory_write_strobe_n |-> data_oe)
    else $error("write strobe without data drive");
  AST_SENSE_PULL: assert property (byte_width_sense_oe |-> !byte_width_sense_out)
    else $error("byte sense driven high");
  AST_BYTE_SEL: assert property (!memory_write_strobe_n |-> !(low_byte_enable_n && high_byte_enable_n))
    else $error("write without byte enable");
  AST_ROM_DEFAULT: assert property ((xfer && !cs_programmed) |-> rom_select_n == addr_out[23])
    else $error("rom select wrong in default map");
  AST_RAM_DEFAULT: assert property ((xfer && ram_map && !ram_word_mode) |-> !ram_select_low_n)
    else $error("low ram select missing");
  AST_ROM_SENSE: assert property ((xfer && !rom_select_n) |-> byte_width_sense_oe == !rom_word_mode)
    else $error("byte sense wrong for rom");
  AST_RAM_SENSE: assert property ((xfer && ram_map) |-> byte_width_sense_oe == !ram_word_mode)
    else $error("byte sense wrong for ram");
  AST_RAM_GATE: assert property ((xfer && ram_map && ram_word_mode) |->
    ram_select_low_n == low_byte_enable_n && ram_select_high_n == high_byte_enable_n) else $error("ram gating wrong");
  AST_WAIT_HOLD: assert property (((!wait_n)[*5] ##0 !column_strobe_reference_n) |=>
    !column_strobe_reference_n) else $error("strobe released during wait");
  AST_NMI: assert property ($fell(nmi_n) |-> ##[1:8] (int_valid && int_source == `MBS_SVC_NMI))
    else $error("nmi not served");
  cover property ($fell(memory_write_strobe_n));
  cover property (!wait_n && !column_strobe_reference_n);
  cover property ($fell(nmi_n));
endmodule : mbs_bus_ctrl_asserts
bind mbs_bus_ctrl mbs_bus_ctrl_asserts mbs_bus_ctrl_asserts_i (.*);
`default_nettype wire

/* mbs_mem_model.sv */
// far-side memory: byte or word device picked by the sense line, with wait states
`timescale 1ns/10ps
`default_nettype none
module mbs_mem_model (
  input  wire logic        clk,
  input  wire logic [23:0] addr_out,
  input  wire logic [15:0] data_out,
  input  wire logic        memory_read_strobe_n,
  input  wire logic        memory_write_strobe_n,
  input  wire logic        high_byte_enable_n,
  input  wire logic        low_byte_enable_n,
  input  wire logic        rom_select_n,
  input  wire logic        ram_select_low_n,
  input  wire logic        byte_width_sense_in,
  input  wire logic [2:0]  stall,
  output logic [15:0]      data_in,
  output logic             wait_n
);
  logic [7:0]  mem_q [0:255];
  logic [15:0] last_q = 16'h0000;
  logic [2:0]  cnt_q = 3'h0;
  logic        sel_q = 1'h0;
  wire logic       sel = !rom_select_n || !ram_select_low_n;
  wire logic [7:0] a = {addr_out[7:1], 1'b0};
  always_ff @(posedge clk) begin
    if (sel && !memory_write_strobe_n) begin
      if (!byte_width_sense_in) mem_q[addr_out[7:0]] <= data_out[7:0];
      else begin
        if (!low_byte_enable_n) mem_q[a] <= data_out[7:0];
        if (!high_byte_enable_n) mem_q[a + 8'h01] <= data_out[15:8];
      end
    end
  end
  // released lanes show the inverse of the last value, never a steady guess
  always_comb begin
    data_in = ~last_q;
    if (sel && !memory_read_strobe_n) begin
      if (byte_width_sense_in) data_in = {mem_q[a + 8'h01], mem_q[a]};
      else data_in = {~last_q[15:8], mem_q[addr_out[7:0]]};
    end
  end
  always_ff @(posedge clk) begin
    last_q <= data_in;
    sel_q <= sel;
    if (sel && !sel_q && stall != 3'h0) cnt_q <= stall - 3'h1;
    else if (cnt_q != 3'h0) cnt_q <= cnt_q - 3'h1;
  end
  // wait falls with the select so it clears the two-flop synchroniser before T3 ends
  assign wait_n = !((sel && !sel_q && stall != 3'h0) || cnt_q != 3'h0);
endmodule : mbs_mem_model
`default_nettype wire

/* memory_bus_strobes_and_selects_tb.sv */
// self-checking bench for the memory bus strobe and select block
`timescale 1ns/10ps
`default_nettype none
`include "mbs_params.svh"
module memory_bus_strobes_and_selects_tb;
  import mbs_pkg::*;
  logic clk = 1'b0, rst_n = 1'b0, req_valid = 1'b0, req_word = 1'b1, cs_programmed = 1'b0, nmi_n = 1'b1;
  logic rom_word_mode = 1'b0, ram_word_mode = 1'b0, ram_high_port_value = 1'b0, io_clock_enable = 1'b0;
  logic int_ack = 1'b0, req_ready, done_pulse, data_oe, memory_read_strobe_n, memory_write_strobe_n;
  logic high_byte_enable_n, low_byte_enable_n, timing_reference_a_n, column_strobe_reference_n;
  logic row_strobe_reference_n, rom_select_n, ram_select_low_n, ram_select_high_n, byte_width_sense_out;
  logic byte_width_sense_oe, wait_n, io_clock, int_valid, io_q, r_q, rd_q, wr_q, rom_seen, ram_seen;
  logic [23:0] req_addr = 24'h000000, rom_base = 24'h800000, rom_mask = 24'hFF0000, addr_out;
  logic [15:0] req_wdata = 16'h0000, rd_data, data_out, data_in;
  logic [3:0]  maskable_irq_inputs_n = 4'hF;
  logic [2:0]  stall = 3'h0, int_source;
  logic [7:0]  ref_mem [0:255];
  mbs_kind_t   req_kind = MBS_MEM_RD;
  mbs_iodiv_t  io_div = MBS_DIV2;
  int bad_count = 0, checks = 0, cyc = 0, rows = 0, strobes = 0, io_last = 0, io_per = 0, seed = 32'h330e;
  // open-drain sense line with a pull-up
  wire logic byte_width_sense_in = (byte_width_sense_oe !== 1'b1);
  mbs_bus_ctrl  mbs_bus_ctrl_i (.*);
  mbs_mem_model mbs_mem_model_i (.*);
  always #2 clk = ~clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    {io_q, r_q, rd_q, wr_q} <= {io_clock, row_strobe_reference_n, memory_read_strobe_n, memory_write_strobe_n};
    if (r_q && !row_strobe_reference_n) rows <= rows + 1;
    if ((rd_q && !memory_read_strobe_n) || (wr_q && !memory_write_strobe_n)) strobes <= strobes + 1;
    if (!row_strobe_reference_n) {rom_seen, ram_seen} <= {!rom_select_n, !ram_select_low_n};
    if (io_clock && !io_q) begin
      io_per <= cyc - io_last;
      io_last <= cyc;
    end
    if (cyc == 8000) begin
      bad_count = bad_count + 1;
      tally_and_finish();
    end
  end
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
    checks = checks + 1;
    if (seen !== exp) begin
      bad_count = bad_count + 1;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask : check
  function automatic logic sig(input int w);
    return w == 0 ? req_ready : (w == 1 ? done_pulse : int_valid);
  endfunction : sig
  task automatic wait_hi(input int w);
    int n;
    n = 0;
    while (sig(w) !== 1'b1 && n < 200) begin
      @(negedge clk);
      n = n + 1;
    end
    check("handshake", 24'(n < 200), 24'h000001);
  endtask : wait_hi
  task automatic req(input mbs_kind_t k, input logic [23:0] ad, input logic [15:0] wd, input int n_tr);
    int r0;
    wait_hi(0);
    @(posedge clk);
    req_valid <= 1'b1;
    req_kind <= k;
    req_addr <= ad;
    req_wdata <= wd;
    stall <= 3'($random(seed));
    r0 = rows;
    @(posedge clk);
    req_valid <= 1'b0;
    wait_hi(1);
    check("transactions", 24'(rows - r0), 24'(n_tr));
  endtask : req
  task automatic mem_op(input logic top, input int n_tr);
    logic [23:0] ad;
    logic [15:0] wd;
    ad = {top, 15'h0000, 8'($random(seed)) & 8'hFE};
    wd = 16'($random(seed));
    ref_mem[ad[7:0]] = wd[7:0];
    ref_mem[ad[7:0] + 8'h01] = wd[15:8];
    req(MBS_MEM_WR, ad, wd, n_tr);
    req(MBS_MEM_RD, ad, 16'h0000, n_tr);
    check("read data", 24'(rd_data), 24'({ref_mem[ad[7:0] + 8'h01], ref_mem[ad[7:0]]}));
    check("rom select", 24'(rom_seen), 24'(!top | cs_programmed));
    check("ram select", 24'(ram_seen), 24'(top & !cs_programmed));
  endtask : mem_op
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : tally_and_finish
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    int s0;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    @(negedge clk);
    check("idle strobes", 24'({memory_read_strobe_n, memory_write_strobe_n, rom_select_n}), 24'h000007);
    for (int c = 0; c < 4; c++) begin
      @(posedge clk);
      {rom_word_mode, ram_word_mode} <= 2'(c);
      ram_high_port_value <= 1'($random(seed));
      for (int i = 0; i < 4; i++) mem_op(i[0], ((i[0] ? c[0] : c[1]) ? 1 : 2));
      if (!c[0]) check("high ram pin", 24'(ram_select_high_n), 24'(!ram_high_port_value));
      $display("test map config %0d done", c);
    end
    @(posedge clk);
    {rom_word_mode, ram_word_mode, cs_programmed} <= 3'h1;
    mem_op(1'b1, 2);
    @(posedge clk);
    cs_programmed <= 1'b0;
    s0 = strobes;
    req(MBS_REFRESH, 24'h000010, 16'h0000, 1);
    check("refresh strobes", 24'(strobes - s0), 24'h000000);
    $display("test programmed rom and refresh done");
    @(posedge clk);
    nmi_n <= 1'b0;
    maskable_irq_inputs_n <= 4'h9;
    // irqs and nmi reach the pins together; the irqs clear the synchroniser one cycle before the nmi edge is latched
    repeat (4) @(posedge clk);
    @(negedge clk);
    for (int k = 0; k < 2; k++) begin
      wait_hi(2);
      check("int source", 24'(int_source), k ? 24'h000001 : 24'(`MBS_SVC_NMI));
      @(posedge clk);
      int_ack <= 1'b1;
      @(posedge clk);
      int_ack <= 1'b0;
      repeat (3) @(posedge clk);
    end
    maskable_irq_inputs_n <= 4'hF;
    nmi_n <= 1'b1;
    io_clock_enable <= 1'b1;
    $display("test interrupts done");
    for (int d = 0; d < 4; d++) begin
      io_div <= mbs_iodiv_t'(d);
      repeat (40) @(posedge clk);
      check("io clock period", 24'(io_per), 24'(2 * d + 2));
      req(MBS_IO, 24'h000010, 16'h0000, 0);
    end
    $display("test io clock done");
    tally_and_finish();
  end
endmodule : memory_bus_strobes_and_selects_tb
`default_nettype wire
